/* File: design/ppfs_top.sv */
// Pin function selection for four multiplexed port pins.
// Assumes all control bits are synchronous to sys_clk.
// Functional notes
// - No refresh while bus is released.
// - Refresh request during release raises release request.
// - Multi-function pin priority: release, I2C, timer, serial.
// - End pin outputs DMA end in expanded mode.
// - End pin feeds irq2 when selected.
// - Transmit pin priority: timer, serial, then port input, pulse, port output.
// - Transmit pin feeds irq1 if selected, DMA always.
// - Capture input B when mode 0000, IO 10xx.
// - Port F0 feeds trigger under select conditions.
`timescale 1ns/1ps
module ppfs_top (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic expanded_mode_enable,
	input wire logic single_chip_mode,
	input wire logic bus_release_enable,
	input wire logic release_req_out_enable,
	input wire logic release_req_pin_select,
	input wire logic bus_granted_away,
	input wire logic refresh_req,
	input wire logic i2c_enable,
	input wire logic timer_a_output,
	input wire logic serial2_tx_enable,
	input wire logic port5_0_direction,
	input wire logic pulse_out0_enable,
	input wire logic dma_end_out_enable,
	input wire logic port8_2_direction,
	input wire logic irq2_pin_select,
	input wire logic timer_b_output,
	input wire logic [3:0] timer_mode_field,
	input wire logic [3:0] timer_io_ctrl_b,
	input wire logic serial_tx_enable,
	input wire logic port8_1_direction,
	input wire logic pulse_out1_enable,
	input wire logic irq1_pin_select,
	input wire logic adc_trigger_pin_select,
	input wire logic trigger_select_hi,
	input wire logic trigger_select_lo,
	input wire logic ext_trigger_select,
	input wire logic pin82_in,
	input wire logic pin81_in,
	input wire logic pinf0_in,
	output logic [2:0] pin50_function,
	output logic pin50_oe,
	output logic bus_release_req_out,
	output logic refresh_go,
	output logic pin82_oe,
	output logic pin82_dma_end_sel,
	output logic irq2_alt_in,
	output logic [2:0] pin81_function,
	output logic pin81_oe,
	output logic irq1_alt_in,
	output logic dma_request_in_ch3,
	output logic timer_capture_b_in,
	output logic adc_trigger0_alt_in
);
	// Refresh hold request from the gate
	logic refresh_pending_req;
	// Decoded functions before registering
	logic [2:0] next_f50;
	logic [2:0] next_f81;

	// Refresh gating during bus release
	ppfs_refresh_gate u_gate (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.bus_granted_away(bus_granted_away),
		.refresh_req(refresh_req),
		.release_req_out_enable(release_req_out_enable),
		.refresh_go(refresh_go),
		.refresh_pending_req(refresh_pending_req)
	);

	// Shared lower-priority port decode
	function automatic logic [2:0] ppfs_port_fn(input logic dir, input logic pulse);
		if (!dir) begin
			ppfs_port_fn = ppfs_pkg::FN50_PORT_IN;
		end else if (pulse) begin
			ppfs_port_fn = ppfs_pkg::FN50_PULSE;
		end else begin
			ppfs_port_fn = ppfs_pkg::FN50_PORT_OUT;
		end
	endfunction : ppfs_port_fn

	// Multi-function pin priority decode
	always_comb begin
		if (bus_release_enable && release_req_out_enable && release_req_pin_select) begin
			next_f50 = ppfs_pkg::FN50_RELREQ;
		end else if (i2c_enable) begin
			next_f50 = ppfs_pkg::FN50_I2C;
		end else if (timer_a_output) begin
			next_f50 = ppfs_pkg::FN50_TIMER;
		end else if (serial2_tx_enable) begin
			next_f50 = ppfs_pkg::FN50_SERIAL;
		end else begin
			next_f50 = ppfs_port_fn(port5_0_direction, pulse_out0_enable);
		end
	end

	// Transmit pin priority decode
	always_comb begin
		if (timer_b_output) begin
			next_f81 = ppfs_pkg::FN50_TIMER;
		end else if (serial_tx_enable) begin
			next_f81 = ppfs_pkg::FN50_SERIAL;
		end else begin
			next_f81 = ppfs_port_fn(port8_1_direction, pulse_out1_enable);
		end
	end

	// Registered function selects
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin50_function <= ppfs_pkg::FN50_PORT_IN;
			pin50_oe <= 1'b0;
			pin81_function <= ppfs_pkg::FN50_PORT_IN;
			pin81_oe <= 1'b0;
		end else begin
			pin50_function <= next_f50;
			pin50_oe <= (next_f50 != ppfs_pkg::FN50_PORT_IN) && (next_f50 != ppfs_pkg::FN50_I2C);
			pin81_function <= next_f81;
			pin81_oe <= next_f81 != ppfs_pkg::FN50_PORT_IN;
		end
	end

	// Release request pin drive
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_release_req_out <= 1'b0;
		end else begin
			bus_release_req_out <= refresh_pending_req
				&& (pin50_function == ppfs_pkg::FN50_RELREQ);
		end
	end

	// DMA end pin decode
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin82_dma_end_sel <= 1'b0;
			pin82_oe <= 1'b0;
		end else begin
			pin82_dma_end_sel <= dma_end_out_enable && expanded_mode_enable
				&& !single_chip_mode;
			pin82_oe <= (dma_end_out_enable && expanded_mode_enable && !single_chip_mode)
				|| port8_2_direction;
		end
	end

	// Alternate inputs routed from the pins
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq2_alt_in <= 1'b0;
			irq1_alt_in <= 1'b0;
			dma_request_in_ch3 <= 1'b0;
			timer_capture_b_in <= 1'b0;
			adc_trigger0_alt_in <= 1'b0;
		end else begin
			irq2_alt_in <= irq2_pin_select && pin82_in;
			irq1_alt_in <= irq1_pin_select && pin81_in;
			dma_request_in_ch3 <= pin81_in;
			timer_capture_b_in <= (timer_mode_field == ppfs_pkg::TMR_MODE_NORMAL)
				&& (timer_io_ctrl_b[3:2] == ppfs_pkg::IOB_CAPTURE_HI) && pin81_in;
			adc_trigger0_alt_in <= adc_trigger_pin_select && !trigger_select_hi
				&& !trigger_select_lo && ext_trigger_select && pinf0_in;
		end
	end

	// Release request wins the pin
	property p_relreq_prio;
		@(posedge sys_clk) disable iff (!nrst)
		bus_release_enable && release_req_out_enable && release_req_pin_select
		|=> pin50_function == ppfs_pkg::FN50_RELREQ;
	endproperty
	a_relreq_prio: assert property (p_relreq_prio)
		else $error("release request lost pin priority");

	// I2C beats the timer
	property p_i2c;
		@(posedge sys_clk) disable iff (!nrst)
		!release_req_pin_select && i2c_enable |=> pin50_function == ppfs_pkg::FN50_I2C;
	endproperty
	a_i2c: assert property (p_i2c)
		else $error("i2c not selected");

	// DMA end only in expanded mode
	property p_dma_end;
		@(posedge sys_clk) disable iff (!nrst)
		pin82_dma_end_sel |-> $past(expanded_mode_enable) && $past(dma_end_out_enable);
	endproperty
	a_dma_end: assert property (p_dma_end)
		else $error("dma end outside expanded mode");

	// irq2 routing gated by select
	property p_irq2;
		@(posedge sys_clk) disable iff (!nrst)
		!irq2_pin_select |=> !irq2_alt_in;
	endproperty
	a_irq2: assert property (p_irq2)
		else $error("irq2 routed without select");

	// Timer top priority on transmit pin
	property p_timer_b;
		@(posedge sys_clk) disable iff (!nrst)
		timer_b_output |=> pin81_function == ppfs_pkg::FN50_TIMER && pin81_oe;
	endproperty
	a_timer_b: assert property (p_timer_b)
		else $error("timer lost transmit pin");

	// DMA request follows the pin
	property p_dreq;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> dma_request_in_ch3 == $past(pin81_in);
	endproperty
	a_dreq: assert property (p_dreq)
		else $error("dma request not following pin");

	// Capture only in matching mode
	property p_cap;
		@(posedge sys_clk) disable iff (!nrst)
		timer_capture_b_in |-> $past(timer_mode_field) == ppfs_pkg::TMR_MODE_NORMAL;
	endproperty
	a_cap: assert property (p_cap)
		else $error("capture in wrong mode");

	// Trigger needs extended select
	property p_trig;
		@(posedge sys_clk) disable iff (!nrst)
		adc_trigger0_alt_in |-> $past(ext_trigger_select) && !$past(trigger_select_hi);
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger routed wrongly");

	// Port decode change lands next cycle
	property p_next;
		@(posedge sys_clk) disable iff (!nrst)
		!timer_b_output && !serial_tx_enable && !port8_1_direction
		|=> pin81_function == ppfs_pkg::FN50_PORT_IN && !pin81_oe;
	endproperty
	a_next: assert property (p_next)
		else $error("port input not decoded");

	c_relreq: cover property (@(posedge sys_clk) disable iff (!nrst) bus_release_req_out);
	c_pulse: cover property (@(posedge sys_clk) disable iff (!nrst)
		pin81_function == ppfs_pkg::FN50_PULSE);
	c_trig: cover property (@(posedge sys_clk) disable iff (!nrst) adc_trigger0_alt_in);
endmodule : ppfs_top

/* File: design/ppfs_pkg.sv */
// Package for the port pin function select block.
// Assumes one system clock domain and plain control-bit ports.
package ppfs_pkg;
	// Function codes of the bus-release multi-function pin
	localparam logic [2:0] FN50_PORT_IN = 3'h0;
	localparam logic [2:0] FN50_PORT_OUT = 3'h1;
	localparam logic [2:0] FN50_PULSE = 3'h2;
	localparam logic [2:0] FN50_TIMER = 3'h3;
	localparam logic [2:0] FN50_SERIAL = 3'h4;
	localparam logic [2:0] FN50_I2C = 3'h5;
	localparam logic [2:0] FN50_RELREQ = 3'h6;
	// Timer mode and I/O control codes
	localparam logic [3:0] TMR_MODE_NORMAL = 4'h0;
	localparam logic [1:0] IOB_CAPTURE_HI = 2'h2;
	// Serial select location code
	localparam logic [1:0] SSEL_LOC_PF0 = 2'h2;
	// Refresh hold states, one-hot
	typedef enum logic [1:0] {
		PPFS_OWNED = 2'h1,
		PPFS_RELEASED = 2'h2
	} ppfs_bus_t;
endpackage : ppfs_pkg

/* File: design/ppfs_refresh_gate.sv */
// Refresh gating while the external bus is released.
// Assumes refresh requests and bus grant are synchronous to sys_clk.
`timescale 1ns/1ps
module ppfs_refresh_gate (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic bus_granted_away,
	input wire logic refresh_req,
	input wire logic release_req_out_enable,
	output logic refresh_go,
	output logic refresh_pending_req
);
	// Bus ownership state
	ppfs_pkg::ppfs_bus_t state;
	ppfs_pkg::ppfs_bus_t next_state;

	// Next ownership state
	always_comb begin
		case (state)
			ppfs_pkg::PPFS_OWNED: next_state = bus_granted_away ? ppfs_pkg::PPFS_RELEASED
				: ppfs_pkg::PPFS_OWNED;
			ppfs_pkg::PPFS_RELEASED: next_state = bus_granted_away ? ppfs_pkg::PPFS_RELEASED
				: ppfs_pkg::PPFS_OWNED;
			default: next_state = ppfs_pkg::PPFS_OWNED;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ppfs_pkg::PPFS_OWNED;
		end else begin
			state <= next_state;
		end
	end

	// Refresh only while bus is owned
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			refresh_go <= 1'b0;
		end else begin
			refresh_go <= refresh_req && !bus_granted_away;
		end
	end

	// Ask for the bus back on a held refresh
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			refresh_pending_req <= 1'b0;
		end else begin
			refresh_pending_req <= refresh_req && bus_granted_away
				&& release_req_out_enable;
		end
	end

	// No refresh issued while released
	property p_no_refresh_released;
		@(posedge sys_clk) disable iff (!nrst)
		$past(bus_granted_away) || state == ppfs_pkg::PPFS_RELEASED |-> !refresh_go;
	endproperty
	a_no_refresh_released: assert property (p_no_refresh_released)
		else $error("refresh issued during bus release");

	// Held refresh requests the bus back
	property p_req_out;
		@(posedge sys_clk) disable iff (!nrst)
		refresh_req && bus_granted_away && release_req_out_enable |=> refresh_pending_req;
	endproperty
	a_req_out: assert property (p_req_out)
		else $error("release request not raised");

	c_held: cover property (@(posedge sys_clk) disable iff (!nrst) refresh_pending_req);
endmodule : ppfs_refresh_gate

/* File: sim/ppfs_board.sv */
// Board model driving the three sensed pin levels of the pin function block.
// Assumes the bench requests levels; pins move only at the falling edge.
`timescale 1ns/1ps
module ppfs_board (
	input wire logic sys_clk,
	input wire logic [2:0] level_req,
	output logic pin82_in,
	output logic pin81_in,
	output logic pinf0_in
);
	// Quiet levels before the first request
	initial begin
		{pinf0_in, pin81_in, pin82_in} = 3'h0;
	end
	// Pins settle away from the sampling edge, like a real board trace
	always @(negedge sys_clk) begin
		pin82_in <= level_req[0];
		pin81_in <= level_req[1];
		pinf0_in <= level_req[2];
	end
endmodule : ppfs_board

/* File: sim/tb_top.sv */
// Self-checking bench for the pin function select block.
// Assumes outputs settle within three clocks of a held input vector.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module tb_top;
	logic sys_clk, nrst, chk; // Clock, reset, compare strobe
	logic [23:0] c; // Loose control bits
	logic [3:0] md, io; // Timer mode and I/O-B control fields
	logic [2:0] lv; // Requested pin levels
	logic [16:0] dout; // All outputs in one bundle
	logic p82, p81, pf0; // Pin levels from the board
	logic [16:0] expq[$]; // Expected bundles, oldest first
	logic [16:0] exp_v; // Oldest expected bundle, popped once per compare
	int n_mismatch = 0, samples_checked = 0, seed = 32'h9D16F31B;
	// Clock generator
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	ppfs_board board (.sys_clk(sys_clk), .level_req(lv), .pin82_in(p82), .pin81_in(p81),
		.pinf0_in(pf0));
	ppfs_top uut (.sys_clk(sys_clk), .nrst(nrst), .expanded_mode_enable(c[0]),
		.single_chip_mode(c[1]), .bus_release_enable(c[2]), .release_req_out_enable(c[3]),
		.release_req_pin_select(c[4]), .bus_granted_away(c[5]), .refresh_req(c[6]),
		.i2c_enable(c[7]), .timer_a_output(c[8]), .serial2_tx_enable(c[9]),
		.port5_0_direction(c[10]), .pulse_out0_enable(c[11]), .dma_end_out_enable(c[12]),
		.port8_2_direction(c[13]), .irq2_pin_select(c[14]), .timer_b_output(c[15]),
		.timer_mode_field(md), .timer_io_ctrl_b(io), .serial_tx_enable(c[16]),
		.port8_1_direction(c[17]), .pulse_out1_enable(c[18]), .irq1_pin_select(c[19]),
		.adc_trigger_pin_select(c[20]), .trigger_select_hi(c[21]),
		.trigger_select_lo(c[22]), .ext_trigger_select(c[23]), .pin82_in(p82),
		.pin81_in(p81), .pinf0_in(pf0), .pin50_function(dout[16:14]), .pin50_oe(dout[13]),
		.bus_release_req_out(dout[12]), .refresh_go(dout[11]), .pin82_oe(dout[10]),
		.pin82_dma_end_sel(dout[9]), .irq2_alt_in(dout[8]), .pin81_function(dout[7:5]),
		.pin81_oe(dout[4]), .irq1_alt_in(dout[3]), .dma_request_in_ch3(dout[2]),
		.timer_capture_b_in(dout[1]), .adc_trigger0_alt_in(dout[0]));
	// Expected output bundle for a held input vector
	function automatic logic [16:0] exp_out(input logic [23:0] c, input logic [3:0] md,
		input logic [3:0] io, input logic [2:0] lv);
		logic [2:0] f50, f81;
		logic sel82;
		if (c[2] && c[3] && c[4]) f50 = ppfs_pkg::FN50_RELREQ;
		else if (c[7]) f50 = ppfs_pkg::FN50_I2C;
		else if (c[8]) f50 = ppfs_pkg::FN50_TIMER;
		else if (c[9]) f50 = ppfs_pkg::FN50_SERIAL;
		else if (!c[10]) f50 = ppfs_pkg::FN50_PORT_IN;
		else f50 = c[11] ? ppfs_pkg::FN50_PULSE : ppfs_pkg::FN50_PORT_OUT;
		if (c[15]) f81 = ppfs_pkg::FN50_TIMER;
		else if (c[16]) f81 = ppfs_pkg::FN50_SERIAL;
		else if (!c[17]) f81 = ppfs_pkg::FN50_PORT_IN;
		else f81 = c[18] ? ppfs_pkg::FN50_PULSE : ppfs_pkg::FN50_PORT_OUT;
		sel82 = c[12] && c[0] && !c[1];
		return {f50, !(f50 == ppfs_pkg::FN50_PORT_IN || f50 == ppfs_pkg::FN50_I2C),
			c[2] & c[3] & c[4] & c[5] & c[6], c[6] & !c[5], sel82 | c[13], sel82,
			lv[0] & c[14], f81, f81 != ppfs_pkg::FN50_PORT_IN, lv[1] & c[19], lv[1],
			lv[1] & (md == ppfs_pkg::TMR_MODE_NORMAL) & (io[3:2] == ppfs_pkg::IOB_CAPTURE_HI),
			lv[2] & c[20] & !c[21] & !c[22] & c[23]};
	endfunction : exp_out
	// Verdict and end of run
	task automatic summarize();
		if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	// Monitor: compares the oldest note whenever a settled result is flagged
	initial begin
		forever begin
			@(posedge sys_clk);
			if (chk === 1'b1) begin
				#1;
				if (expq.size() == 0) begin
					`CHK(1'b1, 1'b0)
				end else begin
					exp_v = expq.pop_front();
					`CHK(dout, exp_v)
				end
			end
		end
	end
	// Watchdog against a hung run
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		summarize();
	end
	// Driver: random held vectors, each noted right after it is applied
	initial begin
		{nrst, chk, c, md, io, lv} = '0;
		repeat (5) @(negedge sys_clk);
		`CHK(dout, 17'h00000)
		nrst = 1'b1;
		// Each pass sets pin-select and function bits together at one falling edge
		for (int i = 0; i < 400; i++) begin
			@(negedge sys_clk);
			chk = 1'b0;
			c = 24'($random(seed));
			md = $random(seed) & 1 ? 4'h0 : 4'($random(seed));
			io = 4'($random(seed));
			lv = 3'($random(seed));
			expq.push_back(exp_out(c, md, io, lv));
			repeat (3) @(negedge sys_clk);
			chk = 1'b1;
		end
		@(negedge sys_clk);
		summarize();
	end
endmodule : tb_top
